// file: core/dsps_cfg_if.sv
// carrier between the pin sharing top and its selection decoder
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface dsps_cfg_if;
   logic feat_en;
   logic mem_fpm;
   logic pin_ras;
   logic wide_bus;
   dsps_pkg::dsps_sel_t sel;

   modport dec (input feat_en, input mem_fpm, input pin_ras, input wide_bus, output sel);
   modport top (output feat_en, output mem_fpm, output pin_ras, output wide_bus, input sel);
endinterface

// file: core/dsps_pin_share.sv
// top of the dram strobe pin sharing block: steers the upper column
// strobes and the shared secondary-enable / second-row-strobe pin
// assumes strobes and register bytes come from logic on clk_i
//
// Notes on behaviour
// - feature connector on: upper column strobes undriven
// - edo memory: secondary enable on shared pin
// - edo, connector off: secondary copies primary enable
// - edo, connector on: secondary enable held high
// - fast page, select clear, wide variant: duplicate primary enable; narrow variant gives second row strobe
// - narrow variant never makes secondary enable
// - fast page, select set: second row strobe
`timescale 1ns/1ns
module dsps_pin_share #(
   parameter bit WIDE_BUS = 1'b1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // configuration register bytes
   input wire logic [7:0] seq_feature_ctrl_reg_i,
   input wire logic [7:0] mem_config_reg_i,
   input wire logic [7:0] seq_pin_select_reg_i,
   // strobes from the memory sequencer, active low; access flag active high
   input wire logic access_active_i,
   input wire logic [7:0] cas_n_i,
   input wire logic primary_out_enable_n_i,
   input wire logic [1:0] row_strobe_n_i,
   // memory pins
   output logic [7:0] cas_n_o,
   output logic [7:0] cas_oe_o,
   output logic primary_out_enable_n_o,
   output logic row_strobe_n_o,
   output logic shared_pin_n_o,
   output logic shared_pin_oe_o,
   // state
   output logic [1:0] sel_o
);
   // --------------------------------------------------------------
   // selection decode
   // --------------------------------------------------------------
   dsps_cfg_if cfg ();

   assign cfg.feat_en = seq_feature_ctrl_reg_i[dsps_pkg::FEAT_EN_BIT];
   assign cfg.mem_fpm = mem_config_reg_i[dsps_pkg::MEM_FPM_BIT];
   assign cfg.pin_ras = seq_pin_select_reg_i[dsps_pkg::PIN_RAS_BIT];
   assign cfg.wide_bus = WIDE_BUS;

   dsps_sel_dec u_dec (
      .cfg(cfg)
   );

   // --------------------------------------------------------------
   // selection state
   // --------------------------------------------------------------
   dsps_pkg::dsps_sel_t sel_q, sel_d;
   logic feat_q, feat_d;

   // the choice only moves between accesses so a strobe never glitches
   // from one source to another while a cycle is open
   always_comb begin
      sel_d = sel_q;
      feat_d = feat_q;
      if (!access_active_i) begin
         sel_d = cfg.sel;
         feat_d = cfg.feat_en;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         sel_q <= dsps_pkg::SEL_RST;
         feat_q <= 1'b0;
      end else begin
         sel_q <= sel_d;
         feat_q <= feat_d;
      end
   end

   // --------------------------------------------------------------
   // pin outputs
   // --------------------------------------------------------------
   logic [7:0] cas_n_q, cas_n_d;
   logic [7:0] cas_oe_q, cas_oe_d;
   logic oe0_q, oe0_d;
   logic row0_q, row0_d;
   logic shr_q, shr_d;
   logic shr_oe_q, shr_oe_d;

   always_comb begin
      cas_n_d = cas_n_i;
      cas_oe_d = dsps_pkg::CAS_OE_RST;
      // upper strobes share pins with pixel data when the connector is on
      if (!WIDE_BUS) begin
         cas_oe_d[7:4] = 4'h_0;
      end else if (feat_d) begin
         cas_oe_d[7:4] = 4'h_0;
      end
      oe0_d = primary_out_enable_n_i;
      row0_d = row_strobe_n_i[0];
      shr_oe_d = 1'b1;
      case (sel_d)
         dsps_pkg::SEL_ROW2: begin
            shr_d = row_strobe_n_i[1];
         end
         dsps_pkg::SEL_DUP_OE: begin
            shr_d = primary_out_enable_n_i;
         end
         dsps_pkg::SEL_OE1_COPY: begin
            shr_d = primary_out_enable_n_i;
         end
         dsps_pkg::SEL_OE1_HOLD: begin
            shr_d = 1'b1;
         end
         default: begin
            shr_d = dsps_pkg::STROBE_RST;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cas_n_q <= dsps_pkg::CAS_N_RST;
         cas_oe_q <= dsps_pkg::CAS_OE_RST;
         oe0_q <= dsps_pkg::STROBE_RST;
         row0_q <= dsps_pkg::STROBE_RST;
         shr_q <= dsps_pkg::STROBE_RST;
         shr_oe_q <= 1'b1;
      end else begin
         cas_n_q <= cas_n_d;
         cas_oe_q <= cas_oe_d;
         oe0_q <= oe0_d;
         row0_q <= row0_d;
         shr_q <= shr_d;
         shr_oe_q <= shr_oe_d;
      end
   end

   assign cas_n_o = cas_n_q;
   assign cas_oe_o = cas_oe_q;
   assign primary_out_enable_n_o = oe0_q;
   assign row_strobe_n_o = row0_q;
   assign shared_pin_n_o = shr_q;
   assign shared_pin_oe_o = shr_oe_q;
   assign sel_o = sel_q;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   logic past_ok_q;
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         past_ok_q <= 1'b0;
      end else begin
         past_ok_q <= 1'b1;
      end
   end

   sequence s_idle_cfg(logic f, logic m, logic p);
      !access_active_i && cfg.feat_en == f && cfg.mem_fpm == m && cfg.pin_ras == p;
   endsequence

   a_cas_hi_off: assert property (
      !access_active_i && cfg.feat_en |=> cas_oe_o[7:4] == 4'h_0)
      else $error("upper column strobes driven with connector on");

   a_cas_lo_on: assert property (
      past_ok_q |-> cas_oe_o[3:0] == 4'h_f)
      else $error("lower column strobes not driven");

   a_edo_sel: assert property (
      (WIDE_BUS) and s_idle_cfg(1'b0, 1'b0, 1'b0) |=> sel_o == dsps_pkg::SEL_OE1_COPY)
      else $error("edo memory did not select secondary enable");

   a_oe1_copy: assert property (
      (WIDE_BUS) and s_idle_cfg(1'b0, 1'b0, cfg.pin_ras)
      |=> shared_pin_n_o == $past(primary_out_enable_n_i))
      else $error("secondary enable differs from primary");

   a_oe1_hold: assert property (
      (WIDE_BUS) and s_idle_cfg(1'b1, 1'b0, cfg.pin_ras)
      |=> shared_pin_n_o)
      else $error("secondary enable not held high");

   a_fpm_dup: assert property (
      (WIDE_BUS) and s_idle_cfg(cfg.feat_en, 1'b1, 1'b0)
      |=> sel_o == dsps_pkg::SEL_DUP_OE && shared_pin_n_o == $past(primary_out_enable_n_i))
      else $error("fast page without duplicate primary enable");

   a_narrow_row: assert property (
      !WIDE_BUS && past_ok_q |-> sel_o == dsps_pkg::SEL_ROW2)
      else $error("narrow variant left second row strobe");

   a_fpm_row2: assert property (
      (WIDE_BUS) and s_idle_cfg(cfg.feat_en, 1'b1, 1'b1)
      |=> shared_pin_n_o == $past(row_strobe_n_i[1]))
      else $error("second row strobe missing on shared pin");

   a_sel_stable: assert property (
      access_active_i |=> $stable(sel_o))
      else $error("shared pin selection changed during access");

   a_pin_driven: assert property (
      past_ok_q |-> shared_pin_oe_o)
      else $error("shared pin left undriven");
endmodule

// file: core/dsps_pkg.sv
// package of the dram strobe pin sharing block: bit positions, reset values
// assumes configuration register bytes are presented on the block's clock
package dsps_pkg;
   // --------------------------------------------------------------
   // configuration bit positions
   // --------------------------------------------------------------
   localparam int unsigned FEAT_EN_BIT = 0;   // seq_feature_ctrl_reg
   localparam int unsigned MEM_FPM_BIT = 2;   // mem_config_reg
   localparam int unsigned PIN_RAS_BIT = 6;   // seq_pin_select_reg
   localparam int unsigned CAS_W = 8;
   localparam int unsigned CAS_HI_LO = 4;

   // --------------------------------------------------------------
   // shared pin selection
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      SEL_ROW2 = 2'b00,
      SEL_DUP_OE = 2'b01,
      SEL_OE1_COPY = 2'b10,
      SEL_OE1_HOLD = 2'b11
   } dsps_sel_t;

   // --------------------------------------------------------------
   // values after reset
   // --------------------------------------------------------------
   localparam dsps_sel_t SEL_RST = SEL_DUP_OE;
   localparam logic STROBE_RST = 1'b1;
   localparam logic [7:0] CAS_N_RST = 8'h_ff;
   localparam logic [7:0] CAS_OE_RST = 8'h_ff;
   localparam logic [1:0] ROW_N_RST = 2'h_3;
endpackage

// file: core/dsps_sel_dec.sv
// shared pin selection decoder, purely combinational
// assumes configuration bits are stable on the block's clock
`timescale 1ns/1ns
module dsps_sel_dec (
   // configuration in, selection out
   dsps_cfg_if.dec cfg
);
   always_comb begin
      if (!cfg.wide_bus) begin
         cfg.sel = dsps_pkg::SEL_ROW2;
      end else if (cfg.mem_fpm) begin
         // fast page never gets the secondary enable
         cfg.sel = cfg.pin_ras ? dsps_pkg::SEL_ROW2 : dsps_pkg::SEL_DUP_OE;
      end else begin
         cfg.sel = cfg.feat_en ? dsps_pkg::SEL_OE1_HOLD : dsps_pkg::SEL_OE1_COPY;
      end
   end
endmodule

// file: test/dsps_dram_model.sv
// behavioural model of the upper display memory half behind the shared pin
// assumes the pin is sampled on the block's clock
`timescale 1ns/1ns
module dsps_dram_model (
   // clock
   input wire logic clk_i,
   // shared pin from the block
   input wire logic shared_pin_n_i,
   input wire logic shared_pin_oe_i,
   // memory drives the shared data lines
   output logic upper_drive_o
);
   // ----------------------------------------------------------
   // data drive
   // ----------------------------------------------------------
   // an undriven pin is read as not asserted, the safe reading for contention
   always_ff @(posedge clk_i) begin
      upper_drive_o <= shared_pin_oe_i & ~shared_pin_n_i;
   end
endmodule

// file: test/tb.sv
// self-checking bench of the pin sharing block, wide and narrow variants
// assumes the design files are compiled first
`timescale 1ns/1ns
module tb;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] feat = 8'h_00, mem = 8'h_00, pin = 8'h_00, cas = 8'h_ff;
   logic act = 1'b0, poe = 1'b1;
   logic [1:0] row = 2'h_3;
   logic [7:0] cas_n_o, cas_oe_o, n_cas_oe;
   logic poe_o, row_o, sh_n, sh_oe, drv;
   logic [1:0] sel_o, n_sel;
   int n_fail = 0;
   int comparisons = 0;
   // connector bit as the block latches it: frozen while an access is open
   logic feat_lat = 1'b0;

   always #25 clk_i = ~clk_i;

   dsps_pin_share dut (.clk_i(clk_i), .rstn_i(rstn_i), .seq_feature_ctrl_reg_i(feat),
      .mem_config_reg_i(mem), .seq_pin_select_reg_i(pin), .access_active_i(act),
      .cas_n_i(cas), .primary_out_enable_n_i(poe), .row_strobe_n_i(row),
      .cas_n_o(cas_n_o), .cas_oe_o(cas_oe_o), .primary_out_enable_n_o(poe_o),
      .row_strobe_n_o(row_o), .shared_pin_n_o(sh_n), .shared_pin_oe_o(sh_oe), .sel_o(sel_o));
   dsps_pin_share #(.WIDE_BUS(1'b0)) dut_narrow (.clk_i(clk_i), .rstn_i(rstn_i),
      .seq_feature_ctrl_reg_i(feat), .mem_config_reg_i(mem), .seq_pin_select_reg_i(pin),
      .access_active_i(act), .cas_n_i(cas), .primary_out_enable_n_i(poe),
      .row_strobe_n_i(row), .cas_n_o(), .cas_oe_o(n_cas_oe), .primary_out_enable_n_o(),
      .row_strobe_n_o(), .shared_pin_n_o(), .shared_pin_oe_o(), .sel_o(n_sel));
   dsps_dram_model partner (.clk_i(clk_i), .shared_pin_n_i(sh_n), .shared_pin_oe_i(sh_oe),
      .upper_drive_o(drv));

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // inputs land by nba on an edge; two edges later the outputs are settled
   task automatic apply(input logic f, input logic m, input logic p, input logic a,
                        input logic oe, input logic [1:0] r);
      @(posedge clk_i);
      feat <= {7'h_00, f};
      mem <= {5'h_00, m, 2'h_0};
      pin <= {1'b0, p, 6'h_00};
      act <= a;
      poe <= oe;
      row <= r;
      cas <= {f, m, p, oe, 4'h_5};
      if (!a) begin
         feat_lat = f;
      end
      repeat (2) @(posedge clk_i);
      #1;
      check("cas_n", cas_n_o, {f, m, p, oe, 4'h_5});
      check("cas_oe", cas_oe_o, feat_lat ? 8'h_0f : 8'h_ff);
      check("narrow_cas_oe", n_cas_oe, 8'h_0f);
      check("narrow_sel", {6'h_00, n_sel}, 8'h_00);
      check("shared_oe", {7'h_00, sh_oe}, 8'h_01);
   endtask

   task automatic t_reset;
      #1;
      check("rst_cas_oe", cas_oe_o, 8'h_ff);
      check("rst_sel", {6'h_00, sel_o}, 8'h_01);
      check("rst_shared", {7'h_00, sh_n}, 8'h_01);
   endtask

   task automatic t_edo;
      apply(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h_3);
      check("edo_sel", {6'h_00, sel_o}, 8'h_02);
      check("edo_copy", {7'h_00, sh_n}, 8'h_00);
      check("edo_mem_drive", {7'h_00, drv}, 8'h_01);
      apply(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h_3);
      check("edo_hold_sel", {6'h_00, sel_o}, 8'h_03);
      check("edo_hold", {7'h_00, sh_n}, 8'h_01);
      check("no_contention", {7'h_00, drv}, 8'h_00);
   endtask

   task automatic t_fpm;
      apply(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h_3);
      check("fpm_dup_sel", {6'h_00, sel_o}, 8'h_01);
      check("fpm_dup", {7'h_00, sh_n}, 8'h_00);
      apply(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 2'h_1);
      check("fpm_row_sel", {6'h_00, sel_o}, 8'h_00);
      check("fpm_row2", {7'h_00, sh_n}, 8'h_00);
      check("row0", {7'h_00, row_o}, 8'h_01);
      check("poe", {7'h_00, poe_o}, 8'h_01);
   endtask

   task automatic t_freeze;
      apply(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h_3);
      check("frozen_sel", {6'h_00, sel_o}, 8'h_00);
      apply(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2'h_3);
      check("thawed_sel", {6'h_00, sel_o}, 8'h_03);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #20000;
      n_fail++;
      print_verdict();
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_reset();
      t_edo();
      t_fpm();
      t_freeze();
      print_verdict();
   end
endmodule
